// [rtl/sem_fifo.sv]
// Purpose: Small flip-flop FIFO with valid and ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   Full and empty come from pointers carrying one extra wrap bit.
`default_nettype none
module sem_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,       // Core clock.
  input  wire logic             rst,       // Asynchronous reset, active high.
  input  wire logic             in_valid,  // Producer offers a word.
  output logic                  in_ready,  // Room for a word.
  input  wire logic [WIDTH-1:0] in_data,   // Word offered.
  output logic                  out_valid, // A word is waiting.
  input  wire logic             out_ready, // Consumer takes the word.
  output logic      [WIDTH-1:0] out_data   // Oldest word.
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;

  // Full when the pointers differ only in the wrap bit.
  assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = mem[rd_ptr[AW-1:0]];

  // Write side.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wr_ptr <= '0;
    else if (in_valid && in_ready)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data;
      wr_ptr              <= wr_ptr + 1'b1;
    end
  end

  // Read side.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_ptr <= '0;
    else if (out_valid && out_ready)
      rd_ptr <= rd_ptr + 1'b1;
  end
endmodule
`default_nettype wire

// [rtl/sem_master.sv]
// Purpose: Command-driven two-wire master for an external serial EEPROM.
// Assumes: Processor writes and reads two byte registers on its register port.
// Notes:   Received bytes pass through a small FIFO before reaching the data register.
`default_nettype none
module sem_master
  import sem_pkg::*;
#(
  parameter int unsigned QUARTER_CYCLES = SEM_QUARTER_CYCLES,
  parameter int unsigned FIFO_DEPTH     = SEM_FIFO_DEPTH
) (
  input  wire logic       I_CORE_CLK,                  // Core clock, 40 MHz.
  input  wire logic       I_SYS_RST,                   // Asynchronous reset, active high.
  input  wire logic [7:0] I_SFR_ADDR,                  // Register address.
  input  wire logic       I_SFR_WR,                    // Register write strobe.
  input  wire logic [7:0] I_SFR_WDATA,                 // Register write data.
  output logic      [7:0] O_SFR_RDATA,                 // Register read data.
  input  wire logic       I_EEPROM_PIN_ROUTE_SELECT,   // Routes the master onto the shared pins.
  input  wire logic       I_GPIO_PIN_CLOCK_SHARE,      // Clock pin level.
  output logic            O_GPIO_PIN_CLOCK_SHARE,      // Clock pin drive value.
  output logic            O_GPIO_PIN_CLOCK_SHARE_OE,   // Clock pin drive enable.
  input  wire logic       I_GPIO_PIN_DATA_SHARE,       // Data pin level.
  output logic            O_GPIO_PIN_DATA_SHARE,       // Data pin drive value.
  output logic            O_GPIO_PIN_DATA_SHARE_OE,    // Data pin drive enable.
  output logic            O_SERIAL_DONE_IRQ            // Completion pulse.
);
  localparam int QW = $clog2(QUARTER_CYCLES);

  sem_state_t  state;
  logic [3:0]  op;
  logic [QW-1:0] qcnt;
  logic [1:0]  quarter;
  logic [3:0]  bitn;
  logic [7:0]  shreg;
  logic [7:0]  data_reg;
  logic        error;
  logic        rx_ack;
  logic        tx_ack;
  logic        busy;
  logic        free_run;
  logic        scl_lvl;
  logic        sda_lvl;
  logic        sda_drv;
  logic [1:0]  sda_sync;
  logic [1:0]  scl_sync;
  logic        tick;
  logic        busy_now;
  logic        cmd_wr;
  logic        cmd_ok;
  logic        data_wr;
  logic        rx_op;
  logic        bit_last;
  logic        next_scl;
  logic        next_sda;
  logic        next_drv;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [7:0]  fifo_out_data;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and status terms.

  // Register writes steer the sequencer only when it is idle.
  assign data_wr  = I_SFR_WR && (I_SFR_ADDR == SEM_ADDR_DATA);
  assign cmd_wr   = I_SFR_WR && (I_SFR_ADDR == SEM_ADDR_CMD_STAT) && !busy && (state == SEM_ST_IDLE);
  assign cmd_ok   = (I_SFR_WDATA[3:0] == SEM_CMD_NOOP) || (I_SFR_WDATA[3:0] == SEM_CMD_RX_ACK) ||
                    (I_SFR_WDATA[3:0] == SEM_CMD_TX) || (I_SFR_WDATA[3:0] == SEM_CMD_STOP) ||
                    (I_SFR_WDATA[3:0] == SEM_CMD_RX_LAST) || (I_SFR_WDATA[3:0] == SEM_CMD_START);
  assign busy_now = (state != SEM_ST_IDLE) || fifo_out_valid;
  assign tick     = (qcnt == QW'(QUARTER_CYCLES - 1));
  assign rx_op    = (op == SEM_CMD_RX_ACK) || (op == SEM_CMD_RX_LAST);
  assign bit_last = (bitn == 4'(SEM_LAST_BIT));
  // A processor write to the data register wins the cycle; the FIFO waits.
  assign fifo_out_ready = !data_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers.

  // Two flops before any logic looks at the pin levels.
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      sda_sync <= 2'h3;
      scl_sync <= 2'h3;
    end
    else
    begin
      sda_sync <= {sda_sync[0], I_GPIO_PIN_DATA_SHARE};
      scl_sync <= {scl_sync[0], I_GPIO_PIN_CLOCK_SHARE};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-bit timebase.

  // Runs during operations and while the clock is left free-running.
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      qcnt    <= '0;
      quarter <= 2'h0;
    end
    else if (cmd_wr || ((state == SEM_ST_IDLE) && !free_run))
    begin
      qcnt    <= '0;
      quarter <= 2'h0;
    end
    else if (tick)
    begin
      qcnt    <= '0;
      quarter <= quarter + 2'h1;
    end
    else
      qcnt <= qcnt + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  // Each bit spends two quarters with the clock low and two with it high.
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      state <= SEM_ST_IDLE;
      op    <= SEM_CMD_NOOP;
      bitn  <= 4'h0;
    end
    else
    begin
      case (state)
        SEM_ST_IDLE:
        begin
          bitn <= 4'h0;
          if (cmd_wr)
          begin
            op <= I_SFR_WDATA[3:0];
            if (I_SFR_WDATA[3:0] == SEM_CMD_START)
              state <= SEM_ST_START;
            else if (I_SFR_WDATA[3:0] == SEM_CMD_STOP)
              state <= SEM_ST_STOP;
            else if ((I_SFR_WDATA[3:0] == SEM_CMD_TX) || (I_SFR_WDATA[3:0] == SEM_CMD_RX_ACK) ||
                     (I_SFR_WDATA[3:0] == SEM_CMD_RX_LAST))
              state <= SEM_ST_XFER;
          end
        end
        SEM_ST_START, SEM_ST_STOP:
        begin
          if (tick && (quarter == 2'h3))
            state <= SEM_ST_IDLE;
        end
        SEM_ST_XFER:
        begin
          if (tick && (quarter == 2'h3))
          begin
            bitn <= bitn + 4'h1;
            if (bit_last)
              state <= rx_op ? SEM_ST_PUSH : SEM_ST_IDLE;
          end
        end
        SEM_ST_PUSH:
        begin
          // Holds busy until the FIFO accepts the received byte.
          if (fifo_in_ready)
            state <= SEM_ST_IDLE;
        end
        default:
          state <= SEM_ST_IDLE;
      endcase
    end
  end

  // Shift register: loaded on transmit, filled while receiving.
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      shreg <= SEM_RST_DATA;
    else if (cmd_wr && (I_SFR_WDATA[3:0] == SEM_CMD_TX))
      shreg <= data_reg;
    else if ((state == SEM_ST_XFER) && !bit_last && tick)
    begin
      if (rx_op && (quarter == 2'h2))
        shreg <= {shreg[6:0], sda_sync[1]};
      else if (!rx_op && (quarter == 2'h3))
        shreg <= {shreg[6:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Free-running clock control.

  // Byte transfers leave the clock toggling until a no-op, start or stop command.
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      free_run <= 1'b0;
    else if (cmd_wr && (I_SFR_WDATA[3:0] == SEM_CMD_NOOP))
      free_run <= 1'b0;
    else if (cmd_wr && ((I_SFR_WDATA[3:0] == SEM_CMD_START) || (I_SFR_WDATA[3:0] == SEM_CMD_STOP)))
      free_run <= 1'b0;
    else if ((state == SEM_ST_XFER) && bit_last && tick && (quarter == 2'h3))
      free_run <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line levels.

  // Next clock level, data level and data drive for each state and quarter.
  always_comb
  begin
    next_scl = 1'b1;
    next_sda = sda_lvl;
    next_drv = sda_drv;
    case (state)
      SEM_ST_START:
      begin
        // Clock stays high throughout, so no stray clock pulse precedes the first bit.
        next_scl = 1'b1;
        next_sda = (quarter < 2'h2);
        next_drv = 1'b1;
      end
      SEM_ST_STOP:
      begin
        next_scl = (quarter != 2'h0);
        next_sda = (quarter >= 2'h2);
        next_drv = 1'b1;
      end
      SEM_ST_XFER:
      begin
        next_scl = quarter[1];
        if (bit_last)
        begin
          next_drv = rx_op;
          next_sda = (op == SEM_CMD_RX_LAST);
        end
        else
        begin
          next_drv = !rx_op;
          next_sda = shreg[7];
        end
      end
      default:
      begin
        next_scl = free_run ? quarter[1] : 1'b1;
      end
    endcase
  end

  // Registered line levels.
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      scl_lvl <= 1'b1;
      sda_lvl <= 1'b1;
      sda_drv <= 1'b0;
    end
    else
    begin
      scl_lvl <= next_scl;
      sda_lvl <= next_sda;
      sda_drv <= next_drv;
    end
  end

  // Pins are driven only while routed onto the shared general-purpose pins.
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      O_GPIO_PIN_CLOCK_SHARE    <= 1'b1;
      O_GPIO_PIN_CLOCK_SHARE_OE <= 1'b0;
      O_GPIO_PIN_DATA_SHARE     <= 1'b1;
      O_GPIO_PIN_DATA_SHARE_OE  <= 1'b0;
    end
    else
    begin
      O_GPIO_PIN_CLOCK_SHARE    <= next_scl;
      O_GPIO_PIN_CLOCK_SHARE_OE <= I_EEPROM_PIN_ROUTE_SELECT;
      O_GPIO_PIN_DATA_SHARE     <= next_sda;
      O_GPIO_PIN_DATA_SHARE_OE  <= I_EEPROM_PIN_ROUTE_SELECT && next_drv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags.

  // Error, acknowledge and busy flags.
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      error  <= SEM_RST_ERROR;
      rx_ack <= SEM_RST_RX_ACK;
      tx_ack <= SEM_RST_TX_ACK;
      busy   <= 1'b0;
    end
    else
    begin
      busy <= busy_now;
      if (cmd_wr)
        error <= !cmd_ok;
      if ((state == SEM_ST_XFER) && !rx_op && bit_last && tick && (quarter == 2'h2))
        rx_ack <= sda_sync[1];
      if ((state == SEM_ST_XFER) && rx_op && bit_last && tick && (quarter == 2'h3))
        tx_ack <= (op == SEM_CMD_RX_LAST);
    end
  end

  // Completion pulse on the falling edge of busy.
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      O_SERIAL_DONE_IRQ <= 1'b0;
    else
      O_SERIAL_DONE_IRQ <= busy && !busy_now;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data register and read port.

  // Processor writes first; otherwise a received byte drains from the FIFO.
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      data_reg <= SEM_RST_DATA;
    else if (data_wr)
      data_reg <= I_SFR_WDATA;
    else if (fifo_out_valid)
      data_reg <= fifo_out_data;
  end

  // Registered read data, selected by address.
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      O_SFR_RDATA <= 8'h00;
    else if (I_SFR_ADDR == SEM_ADDR_DATA)
      O_SFR_RDATA <= data_reg;
    else if (I_SFR_ADDR == SEM_ADDR_CMD_STAT)
      O_SFR_RDATA <= {error, busy, rx_ack, tx_ack, 4'h0};
    else
      O_SFR_RDATA <= 8'h00;
  end

  // Received-byte buffer between the shifter and the data register.
  sem_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (I_CORE_CLK),
    .rst       (I_SYS_RST),
    .in_valid  (state == SEM_ST_PUSH),
    .in_ready  (fifo_in_ready),
    .in_data   (shreg),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_route;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    !I_EEPROM_PIN_ROUTE_SELECT |=> !O_GPIO_PIN_CLOCK_SHARE_OE && !O_GPIO_PIN_DATA_SHARE_OE;
  endproperty
  a_route: assert property (p_route) else $error("pins driven while not routed");

  property p_irq;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    $fell(busy) |-> O_SERIAL_DONE_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt when busy fell");

  property p_bad_cmd;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    cmd_wr && !cmd_ok |=> error && (state == SEM_ST_IDLE);
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("illegal command mishandled");

  property p_tx_load;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    cmd_wr && (I_SFR_WDATA[3:0] == SEM_CMD_TX) |=> (state == SEM_ST_XFER) && (shreg == $past(data_reg));
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("transmit did not load data");

  property p_start;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    cmd_wr && (I_SFR_WDATA[3:0] == SEM_CMD_START) |=> (state == SEM_ST_START) ##1 scl_lvl && sda_lvl;
  endproperty
  a_start: assert property (p_start) else $error("start sequence wrong");

  property p_stop;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    cmd_wr && (I_SFR_WDATA[3:0] == SEM_CMD_STOP) |=> (state == SEM_ST_STOP) ##1 !scl_lvl && !sda_lvl;
  endproperty
  a_stop: assert property (p_stop) else $error("stop sequence wrong");

  property p_noop;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    cmd_wr && (I_SFR_WDATA[3:0] == SEM_CMD_NOOP) |=> !free_run ##1 scl_lvl [*3];
  endproperty
  a_noop: assert property (p_noop) else $error("clock not halted");

  property p_ack_drive;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (state == SEM_ST_XFER) && bit_last && rx_op |-> next_drv && (next_sda == (op == SEM_CMD_RX_LAST));
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("acknowledge bit wrong");

  property p_rx_data;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    fifo_out_valid && !data_wr |=> (data_reg == $past(fifo_out_data)) ##1 !$rose(busy);
  endproperty
  a_rx_data: assert property (p_rx_data) else $error("received byte not loaded");

  property p_idle_high;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (state == SEM_ST_IDLE) && !free_run ##1 (state == SEM_ST_IDLE) |=> scl_lvl;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("clock not high when idle");
endmodule
`default_nettype wire

// [rtl/sem_pkg.sv]
// Purpose: Shared constants for the serial EEPROM master.
// Assumes: A 40 MHz core clock and a processor special-function register port.
// Notes:   Offsets, field positions, command codes, reset values and timing live here.
`default_nettype none
package sem_pkg;
  // Special-function register addresses.
  localparam logic [7:0] SEM_ADDR_DATA     = 8'h9e;
  localparam logic [7:0] SEM_ADDR_CMD_STAT = 8'h9f;
  // Command/status field positions.
  localparam int SEM_BIT_ERROR  = 7;
  localparam int SEM_BIT_BUSY   = 6;
  localparam int SEM_BIT_RX_ACK = 5;
  localparam int SEM_BIT_TX_ACK = 4;
  // Command codes in the low nibble.
  localparam logic [3:0] SEM_CMD_NOOP    = 4'h0;
  localparam logic [3:0] SEM_CMD_RX_ACK  = 4'h2;
  localparam logic [3:0] SEM_CMD_TX      = 4'h3;
  localparam logic [3:0] SEM_CMD_STOP    = 4'h5;
  localparam logic [3:0] SEM_CMD_RX_LAST = 4'h6;
  localparam logic [3:0] SEM_CMD_START   = 4'h9;
  // Reset values of the flags and the data register.
  localparam logic       SEM_RST_ERROR  = 1'b0;
  localparam logic       SEM_RST_RX_ACK = 1'b1;
  localparam logic       SEM_RST_TX_ACK = 1'b1;
  localparam logic [7:0] SEM_RST_DATA   = 8'h00;
  // Serial clock timing: four quarter phases per bit.
  localparam int unsigned SEM_CLK_FREQ_HZ    = 40_000_000;
  localparam int unsigned SEM_SCL_FREQ_HZ    = 78_000;
  localparam int unsigned SEM_QUARTER_CYCLES = SEM_CLK_FREQ_HZ / (4 * SEM_SCL_FREQ_HZ);
  localparam int unsigned SEM_LAST_BIT       = 8;
  localparam int unsigned SEM_FIFO_DEPTH     = 4;
  // Sequencer states, Gray coded along idle, start, transfer, push.
  typedef enum logic [2:0]
  {
    SEM_ST_IDLE  = 3'b000,
    SEM_ST_START = 3'b001,
    SEM_ST_XFER  = 3'b011,
    SEM_ST_PUSH  = 3'b010,
    SEM_ST_STOP  = 3'b110
  } sem_state_t;
endpackage
`default_nettype wire

// [verification/sem_eeprom_model.sv]
// Purpose: Behavioural serial EEPROM on the two-wire bus.
// Assumes: Both lines are open drain with pull-ups.
// Notes:   Counts starts, stops and clock rises for the bench.
`default_nettype none
module sem_eeprom_model (
  input  wire logic       i_scl,     // Clock line level.
  input  wire logic       i_sda,     // Data line level.
  input  wire logic       i_rd,      // Send i_rd_byte.
  input  wire logic [7:0] i_rd_byte, // Byte to send.
  input  wire logic       i_ack_en,  // Acknowledge bytes.
  output logic            o_sda_low, // Pulls data low.
  output logic      [7:0] o_byte,    // Last byte seen.
  output logic            o_ack,     // Ninth bit level.
  output int              o_starts,  // Start count.
  output int              o_stops,   // Stop count.
  output int              o_edges,   // Clock rises.
  output int              o_period   // Clock period in ns.
);
  timeunit 1ns;
  timeprecision 1ps;
  int         cnt  = 0;
  int         drv  = 0;
  int         last = 0;
  logic [7:0] sh   = 8'h00;
  // Counters start from zero.
  initial
  begin
    o_starts = 0;
    o_stops = 0;
    o_edges = 0;
    o_period = 0;
    o_byte = 8'h00;
    o_ack = 1'b1;
  end
  // Start is a data fall while the clock is high; the short wait lets a clock fall in the same step settle.
  always @(negedge i_sda)
  begin
    #1;
    if (i_scl)
    begin
      o_starts++;
      cnt = 0;
      drv = 0;
    end
  end
  // Stop is a data rise while the clock is high.
  always @(posedge i_sda)
  begin
    #1;
    if (i_scl)
      o_stops++;
  end
  // Bits are taken on clock rises, the ninth is the acknowledge.
  always @(posedge i_scl)
  begin
    o_edges++;
    o_period = int'($time) - last;
    last = int'($time);
    if (cnt == 8)
    begin
      o_byte = sh;
      o_ack = i_sda;
    end
    sh = {sh[6:0], i_sda};
    cnt = (cnt == 8) ? 0 : cnt + 1;
  end
  // The clock pin is only read, never pulled, so no stretching.
  always @(negedge i_scl) drv = cnt;
  // Data is driven while the clock is low; acknowledge on the ninth bit.
  assign o_sda_low = (drv < 8) ? (i_rd & ~i_rd_byte[7 - drv]) : (~i_rd & i_ack_en);
endmodule
`default_nettype wire

// [verification/tb_sem_master.sv]
// Purpose: Self-checking bench for the serial EEPROM master.
// Assumes: Quarter phase shortened to 4 core cycles.
// Notes:   Pins resolve as open drain with pull-ups.
`default_nettype none
module tb_sem_master
  import sem_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 4;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, route = 1'b1, rd_m = 1'b0, ack_en = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rd_b = 8'h00, m_byte;
  logic       scl_o, scl_oe, sda_o, sda_oe, irq, m_low, m_ack;
  wire        scl, sda;
  int         starts, stops, edges, per, irq_cnt = 0, bad_count = 0, check_count = 0;
  logic [3:0] ill [10] = '{4'h1, 4'h4, 4'h7, 4'h8, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
  // Clock, wired lines and completion pulse counter.
  always #12.5 clk = ~clk;
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (sda_oe ? sda_o : 1'b1) & ~m_low;
  always @(negedge clk) if (irq === 1'b1) irq_cnt++;
  sem_master #(.QUARTER_CYCLES(Q), .FIFO_DEPTH(4)) u_dut (
    .I_CORE_CLK(clk), .I_SYS_RST(rst), .I_SFR_ADDR(addr), .I_SFR_WR(wr),
    .I_SFR_WDATA(wdata), .O_SFR_RDATA(rdata), .I_EEPROM_PIN_ROUTE_SELECT(route),
    .I_GPIO_PIN_CLOCK_SHARE(scl), .O_GPIO_PIN_CLOCK_SHARE(scl_o),
    .O_GPIO_PIN_CLOCK_SHARE_OE(scl_oe), .I_GPIO_PIN_DATA_SHARE(sda),
    .O_GPIO_PIN_DATA_SHARE(sda_o), .O_GPIO_PIN_DATA_SHARE_OE(sda_oe),
    .O_SERIAL_DONE_IRQ(irq));
  sem_eeprom_model u_eeprom (
    .i_scl(scl), .i_sda(sda), .i_rd(rd_m), .i_rd_byte(rd_b), .i_ack_en(ack_en),
    .o_sda_low(m_low), .o_byte(m_byte), .o_ack(m_ack), .o_starts(starts),
    .o_stops(stops), .o_edges(edges), .o_period(per));
  ////////////////////////////////////////////////////////////////////////////
  // Compares one byte and counts the outcome.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Register write, one strobe cycle.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // Register read, data registered one edge later.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    d = rdata;
  endtask
  // Issues a command and waits for the busy flag to drop.
  task automatic cmd(input logic [3:0] c);
    logic [7:0] s;
    int         n;
    n = irq_cnt;
    s = 8'hff;
    wr_reg(SEM_ADDR_CMD_STAT, {4'h0, c});
    repeat (3) @(negedge clk);
    for (int i = 0; i < 3000 && s[SEM_BIT_BUSY] !== 1'b0; i++) rd_reg(SEM_ADDR_CMD_STAT, s);
    chk(s & 8'h40, 8'h00);
    if (c inside {SEM_CMD_RX_ACK, SEM_CMD_TX, SEM_CMD_STOP, SEM_CMD_RX_LAST, SEM_CMD_START})
      chk(8'(irq_cnt - n), 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] d;
    rd_reg(SEM_ADDR_CMD_STAT, d);
    chk(d, 8'h30);
    rd_reg(SEM_ADDR_DATA, d);
    chk(d, SEM_RST_DATA);
    rd_reg(8'h10, d);
    chk(d, 8'h00);
  endtask
  task automatic t_route();
    route = 1'b0;
    repeat (3) @(negedge clk);
    chk({6'h0, scl_oe, sda_oe}, 8'h00);
    route = 1'b1;
    repeat (3) @(negedge clk);
    chk({7'h0, scl_oe}, 8'h01);
  endtask
  // Start, one byte out, free-running clock, then halt.
  task automatic t_tx(input logic [7:0] b, input logic ack);
    logic [7:0] d;
    int         e;
    e = starts;
    cmd(SEM_CMD_START);
    chk(8'(starts - e), 8'h01);
    ack_en = ack;
    wr_reg(SEM_ADDR_DATA, b);
    cmd(SEM_CMD_TX);
    chk(m_byte, b);
    rd_reg(SEM_ADDR_CMD_STAT, d);
    chk(d & 8'h20, ack ? 8'h00 : 8'h20);
    ack_en = 1'b0;
    e = edges;
    repeat (100) @(negedge clk);
    chk({7'h0, edges > e}, 8'h01);
    chk(8'(per / 4), 8'(Q * 25));
    cmd(SEM_CMD_NOOP);
    e = edges;
    repeat (100) @(negedge clk);
    chk({7'h0, edges == e}, 8'h01);
    chk({7'h0, scl}, 8'h01);
  endtask
  // Start, one byte in with or without acknowledge.
  task automatic t_rx(input logic [3:0] c, input logic [7:0] b);
    logic [7:0] d;
    cmd(SEM_CMD_START);
    rd_m = 1'b1;
    rd_b = b;
    cmd(c);
    rd_m = 1'b0;
    rd_reg(SEM_ADDR_DATA, d);
    chk(d, b);
    chk({7'h0, m_ack}, c == SEM_CMD_RX_LAST ? 8'h01 : 8'h00);
    rd_reg(SEM_ADDR_CMD_STAT, d);
    chk(d & 8'h10, c == SEM_CMD_RX_LAST ? 8'h10 : 8'h00);
    cmd(SEM_CMD_NOOP);
  endtask
  task automatic t_stop();
    int e;
    e = stops;
    cmd(SEM_CMD_STOP);
    chk(8'(stops - e), 8'h01);
  endtask
  // Every undefined code flags an error and leaves the bus alone.
  task automatic t_err();
    logic [7:0] d;
    int         e;
    e = starts + stops;
    foreach (ill[i])
    begin
      cmd(ill[i]);
      rd_reg(SEM_ADDR_CMD_STAT, d);
      chk(d & 8'h80, 8'h80);
    end
    chk(8'(starts + stops - e), 8'h00);
    cmd(SEM_CMD_NOOP);
    rd_reg(SEM_ADDR_CMD_STAT, d);
    chk(d & 8'h80, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Main sequence; each command waits for busy low before returning.
  initial
  begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_route();
    t_tx(8'h5a, 1'b1);
    t_tx(8'hc3, 1'b0);
    t_rx(SEM_CMD_RX_ACK, 8'ha5);
    t_rx(SEM_CMD_RX_LAST, 8'h96);
    t_stop();
    t_err();
    report_and_stop();
  end
  // Watchdog, far beyond the expected run.
  initial
  begin
    #2_000_000;
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
